// File: design/step_accum.sv
// Purpose: Velocity driven microstep pulse generator (phase accumulator)
// Assumes: Signed velocity, same clock as the register block
// Notes: One pulse per accumulator overflow
`timescale 1ns/10ps
module step_accum #(
   parameter int VEL_W = 24
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Velocity
   input wire logic [VEL_W-1:0] velocity,
   // Step request
   output logic step_r,
   output logic dir_r
);
   logic [VEL_W-1:0] acc_r;
   logic [VEL_W-1:0] mag;
   logic [VEL_W:0] sum;

   always_comb begin
      mag = velocity[VEL_W-1] ? VEL_W'(-velocity) : velocity;
      sum = {1'b0, acc_r} + {1'b0, mag};
   end

   // Magnitude added every cycle, no ramp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= '0;
         step_r <= 1'b0;
         dir_r <= 1'b0;
      end else begin
         acc_r <= sum[VEL_W-1:0];
         step_r <= sum[VEL_W] & (velocity != '0);
         dir_r <= velocity[VEL_W-1];
      end
   end
endmodule

// File: design/step_generator_and_diag_flags.sv
// Purpose: Microstep generator, step interval, position count, diagnostic flags
// Assumes: APB slave, pins synchronised by two flip-flops
// Notes: Sensor inputs are digital level outputs of the analog monitors
//
// Function
// - Internal steps at velocity times clock over 2^24, by phase accumulator.
// - Velocity is two's complement; sign gives direction, magnitude gives rate.
// - New velocity takes effect at once, no ramp.
// - Step interval is the clock count between successive microsteps.
// - Diag pin in step mode toggles once per executed microstep.
// - Position counter wraps from 1023 to 0 going forward.
// - Prewarning flag at the 120C level, shutdown flag at 150C.
// - After shutdown, bridges stay off until below the prewarning level.
// - A short is confirmed by three retries before switching off.
// - Confirmed short switches both bridges off and sets its phase flag.
// - After a short the driver stays off until disabled and re-enabled.
// - Open-load flag set when coil current cannot be reached.
// - Open-load flags take no protective action.
// - Diag pin in error mode is active on overtemperature shutdown or a confirmed short.
// - Diag pin in index mode is active at position zero.
// - Diag pin function selected by configuration bits.
// - Position spans 1024 counts, moved by step width per step.
`timescale 1ns/10ps
`include "stepgen_diag_regs.svh"
module step_generator_and_diag_flags #(
   parameter int VEL_W = 24,
   parameter int INT_W = 20
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Step and direction pins
   input wire logic step_in,
   input wire logic dir_in,
   // Temperature sensor levels
   input wire logic temp_warn_in,
   input wire logic temp_shut_in,
   // Short and open-load detectors
   input wire logic short_gnd_a_in,
   input wire logic short_gnd_b_in,
   input wire logic short_sup_a_in,
   input wire logic short_sup_b_in,
   input wire logic open_load_a_in,
   input wire logic open_load_b_in,
   // Driver outputs
   output logic bridge_enable,
   output logic diag_out,
   output logic [`MICROSTEP_POSITION_COUNT_W-1:0] microstep_position_count,
   output stepgen_diag_pkg::cond_flags_t driver_condition_flags
);
   import stepgen_diag_pkg::*;

   localparam int NSYNC = 10;

   global_config_t global_config_r;
   cond_flags_t cond_r;
   logic [VEL_W-1:0] velocity_setpoint_r;
   logic [INT_W-1:0] step_interval_cycles_r;
   logic [INT_W-1:0] since_step_r;
   logic [`MICROSTEP_POSITION_COUNT_W-1:0] microstep_position_count_r;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   logic step_prev_r;
   logic [3:0] short_prev_r;
   logic [2:0] retry_r [4];
   logic [3:0] short_r;
   logic ot_r;
   logic bridge_en_r;
   logic toggle_r;
   logic diag_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic gen_step;
   logic gen_dir;
   logic int_active;
   logic step_ev;
   logic step_dir;
   logic exec;
   logic setup;
   logic wr_do;
   logic short_clr;
   logic [3:0] short_lvl;

   function automatic logic [`MICROSTEP_POSITION_COUNT_W-1:0] step_width(input logic [3:0] res);
      logic [3:0] r;
      r = (res > `MAX_RES_LOG2) ? `MAX_RES_LOG2 : res;
      step_width = `MICROSTEP_POSITION_COUNT_W'(1) << r;
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `GLOBAL_CONFIG_OFS) || (a == `VELOCITY_SETPOINT_OFS) ||
               (a == `STEP_INTERVAL_OFS) || (a == `MICROSTEP_POS_OFS) ||
               (a == `COND_FLAGS_OFS);
   endfunction

   // Pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {open_load_b_in, open_load_a_in, short_sup_b_in, short_sup_a_in,
                    short_gnd_b_in, short_gnd_a_in, temp_shut_in, temp_warn_in,
                    dir_in, step_in};
         sync_r <= meta_r;
      end
   end

   // APB handshake, one wait-free access phase
   assign setup = psel & ~penable;
   assign wr_do = psel & penable & pready_r & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup & ~mapped(paddr);
         if (setup && !pwrite) begin
            unique case (paddr)
               `GLOBAL_CONFIG_OFS: prdata_r <= {24'h00_0000, global_config_r.res_log2, 1'b0,
                                              global_config_r.drv_en, global_config_r.diag_step,
                                              global_config_r.diag_index};
               `VELOCITY_SETPOINT_OFS: prdata_r <= 32'(velocity_setpoint_r);
               `STEP_INTERVAL_OFS: prdata_r <= 32'(step_interval_cycles_r);
               `MICROSTEP_POS_OFS: prdata_r <= 32'(microstep_position_count_r);
               `COND_FLAGS_OFS: prdata_r <= 32'(cond_r);
               default: prdata_r <= 32'h0000_0000;
            endcase
         end else if (setup) begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // Register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_config_r <= `CFG_RESET;
         velocity_setpoint_r <= '0;
      end else if (wr_do) begin
         if (paddr == `GLOBAL_CONFIG_OFS) begin
            global_config_r.diag_index <= pwdata[`CFG_DIAG_INDEX_BIT];
            global_config_r.diag_step <= pwdata[`CFG_DIAG_STEP_BIT];
            global_config_r.drv_en <= pwdata[`CFG_DRV_EN_BIT];
            global_config_r.res_log2 <= pwdata[`CFG_RES_MSB:`CFG_RES_LSB];
         end
         if (paddr == `VELOCITY_SETPOINT_OFS) begin
            velocity_setpoint_r <= pwdata[VEL_W-1:0];
         end
      end
   end

   // Internal generator
   step_accum #(.VEL_W(VEL_W)) u_accum (
      .pclk(pclk),
      .presetn(presetn),
      .velocity(velocity_setpoint_r),
      .step_r(gen_step),
      .dir_r(gen_dir)
   );

   // Step source select
   assign int_active = velocity_setpoint_r != '0;
   assign step_ev = int_active ? gen_step : (sync_r[0] & ~step_prev_r);
   assign step_dir = int_active ? gen_dir : sync_r[1];
   assign exec = step_ev & bridge_en_r;

   // Microstep position
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_prev_r <= 1'b0;
         microstep_position_count_r <= '0;
      end else begin
         step_prev_r <= sync_r[0];
         if (exec) begin
            if (step_dir) begin
               microstep_position_count_r <= microstep_position_count_r - step_width(global_config_r.res_log2);
            end else begin
               microstep_position_count_r <= microstep_position_count_r + step_width(global_config_r.res_log2);
            end
         end
      end
   end

   // Step interval measure, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_step_r <= '0;
         step_interval_cycles_r <= '0;
      end else if (step_ev) begin
         step_interval_cycles_r <= (since_step_r == '1) ? since_step_r :
                                   since_step_r + INT_W'(1);
         since_step_r <= '0;
      end else if (since_step_r != '1) begin
         since_step_r <= since_step_r + INT_W'(1);
      end
   end

   // Overtemperature hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ot_r <= 1'b0;
      end else if (sync_r[3]) begin
         ot_r <= 1'b1;
      end else if (!sync_r[2]) begin
         ot_r <= 1'b0;
      end
   end

   // Short retry and latch
   assign short_lvl = sync_r[7:4];
   assign short_clr = wr_do && (paddr == `GLOBAL_CONFIG_OFS) && !pwdata[`CFG_DRV_EN_BIT];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         short_prev_r <= '0;
         short_r <= '0;
         for (int i = 0; i < 4; i++) begin
            retry_r[i] <= '0;
         end
      end else begin
         short_prev_r <= short_lvl;
         for (int i = 0; i < 4; i++) begin
            if (short_lvl[i] && !short_prev_r[i]) begin
               if (retry_r[i] == `SHORT_RETRIES) begin
                  short_r[i] <= 1'b1;
               end else begin
                  retry_r[i] <= retry_r[i] + 3'h1;
               end
            end else if (short_clr) begin
               short_r[i] <= 1'b0;
               retry_r[i] <= '0;
            end
         end
      end
   end

   // Bridge enable, open load excluded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_en_r <= 1'b0;
      end else begin
         bridge_en_r <= global_config_r.drv_en & ~ot_r & ~|short_r;
      end
   end

   // Condition flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_r <= '0;
      end else begin
         cond_r.overtemp_shutdown_flag <= ot_r;
         cond_r.otpw <= sync_r[2];
         cond_r.phase_a_ground_short_flag <= short_r[0];
         cond_r.phase_b_ground_short_flag <= short_r[1];
         cond_r.phase_a_supply_short_flag <= short_r[2];
         cond_r.phase_b_supply_short_flag <= short_r[3];
         cond_r.ola <= sync_r[8];
         cond_r.olb <= sync_r[9];
      end
   end

   // Diagnostic pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_r <= 1'b0;
         diag_r <= 1'b0;
      end else begin
         if (exec) begin
            toggle_r <= ~toggle_r;
         end
         if (global_config_r.diag_step) begin
            diag_r <= toggle_r;
         end else if (global_config_r.diag_index) begin
            diag_r <= microstep_position_count_r == '0;
         end else begin
            diag_r <= ot_r | (|short_r);
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign bridge_enable = bridge_en_r;
   assign diag_out = diag_r;
   assign microstep_position_count = microstep_position_count_r;
   assign driver_condition_flags = cond_r;
endmodule

// File: design/stepgen_diag_pkg.sv
// Purpose: Types shared by the step generator and diagnostic flag logic
// Assumes: Constants come from stepgen_diag_regs.svh
// Notes: None
package stepgen_diag_pkg;
   typedef struct packed {
      logic [3:0] res_log2;
      logic drv_en;
      logic diag_step;
      logic diag_index;
   } global_config_t;

   typedef struct packed {
      logic olb;
      logic ola;
      logic phase_b_supply_short_flag;
      logic phase_a_supply_short_flag;
      logic phase_b_ground_short_flag;
      logic phase_a_ground_short_flag;
      logic otpw;
      logic overtemp_shutdown_flag;
   } cond_flags_t;
endpackage

// File: design/stepgen_diag_regs.svh
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by the step_generator_and_diag_flags module only
`ifndef STEPGEN_DIAG_REGS_SVH
`define STEPGEN_DIAG_REGS_SVH

// Register byte offsets
`define GLOBAL_CONFIG_OFS 8'h00
`define VELOCITY_SETPOINT_OFS 8'h04
`define STEP_INTERVAL_OFS 8'h08
`define MICROSTEP_POS_OFS 8'h0c
`define COND_FLAGS_OFS 8'h10

// Global config fields
`define CFG_DIAG_INDEX_BIT 0
`define CFG_DIAG_STEP_BIT 1
`define CFG_DRV_EN_BIT 2
`define CFG_RES_LSB 4
`define CFG_RES_MSB 7
`define CFG_RESET 7'h00

// Condition flag fields
`define FLG_OT_BIT 0
`define FLG_OTPW_BIT 1
`define FLG_PHASE_A_GROUND_SHORT_FLAG_BIT 2
`define FLG_PHASE_B_GROUND_SHORT_FLAG_BIT 3
`define FLG_S2VA_BIT 4
`define FLG_S2VB_BIT 5
`define FLG_OLA_BIT 6
`define FLG_OLB_BIT 7

// Counts
`define SHORT_RETRIES 3'h3
`define MAX_RES_LOG2 4'h8
`define MICROSTEP_POSITION_COUNT_W 10

`endif

// File: sim/host_pins.sv
// Purpose: Host side pins: step and short pulses, diag toggle timer
// Assumes: Pulses of 4 cycles, long enough for the synchroniser
// Notes: Idle pins sit low
`timescale 1ns/10ps
module host_pins (
   // Clock
   input wire logic pclk,
   // Pulse pins
   output logic step_pin,
   output logic short_pin,
   // Timer input
   input wire logic diag_pin,
   output int toggle_cnt
);
   logic diag_d = 1'h0;
   logic step_q = 1'h0;
   logic short_q = 1'h0;
   int cnt = 0;
   assign step_pin = step_q;
   assign short_pin = short_q;
   assign toggle_cnt = cnt;
   always @(posedge pclk) begin
      diag_d <= diag_pin;
      if (diag_pin !== diag_d)
         cnt <= cnt + 1;
   end
   task automatic pulse(input logic sel, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (sel)
            short_q <= 1'h1;
         else
            step_q <= 1'h1;
         repeat (4) @(posedge pclk);
         step_q <= 1'h0;
         short_q <= 1'h0;
         repeat (3) @(posedge pclk);
      end
   endtask
endmodule

// File: sim/step_generator_and_diag_flags_tb.sv
// Purpose: Self-checking bench for the step generator and flags
// Assumes: Wait-free APB slave
// Notes: Sensors driven directly, pulses by host_pins
`timescale 1ns/10ps
module step_generator_and_diag_flags_tb;
   import stepgen_diag_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic warn = 1'h0, shut = 1'h0, ol = 1'h0, dir = 1'h0, shb = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, p0;
   logic pready, pslverr, err, bridge_enable, diag_out, step_pin, short_pin;
   logic [9:0] pos, pos_d;
   cond_flags_t flags;
   int miscompares = 0, checks_done = 0, cycles = 0, tog, c0;
   logic [31:0] cfgs [3] = '{32'h6, 32'h26, 32'h86};
   logic [31:0] vels [3] = '{32'h100000, 32'hf00000, 32'h100000};
   logic [31:0] dels [3] = '{32'ha, 32'h3d8, 32'h200};
   step_generator_and_diag_flags step_generator_and_diag_flags_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .step_in(step_pin),
      .dir_in(dir), .temp_warn_in(warn), .temp_shut_in(shut),
      .short_gnd_a_in(short_pin & ~shb), .short_gnd_b_in(short_pin & shb),
      .short_sup_a_in(short_pin & shb), .short_sup_b_in(short_pin & ~shb),
      .open_load_a_in(ol), .open_load_b_in(ol), .bridge_enable, .diag_out,
      .microstep_position_count(pos), .driver_condition_flags(flags));
   host_pins host_pins_inst (.pclk, .step_pin, .short_pin, .diag_pin(diag_out),
      .toggle_cnt(tog));
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      pos_d <= pos;
      if (cycles == 5000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      rchk(8'h00, 32'h0);
      apb(1'h0, 8'h14, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
      for (int i = 0; i < 3; i++) begin
         apb(1'h1, 8'h00, cfgs[i]);
         rchk(8'h00, cfgs[i]);
         apb(1'h1, 8'h04, vels[i]);
         repeat (40) @(posedge pclk);
         rchk(8'h08, 32'h10);
         apb(1'h0, 8'h0c, 32'h0);
         p0 = rd;
         c0 = tog;
         repeat (157) @(posedge pclk);
         rchk(8'h0c, (p0 + dels[i]) & 32'h3ff);
         chk(tog - c0, 32'ha);
      end
      apb(1'h1, 8'h00, 32'h85);
      @(posedge pclk);
      repeat (64) begin
         @(posedge pclk);
         chk(diag_out, pos_d == 10'h0);
      end
      apb(1'h1, 8'h04, 32'h80000);
      apb(1'h1, 8'h04, 32'h0);
      apb(1'h1, 8'h00, 32'h4);
      apb(1'h0, 8'h0c, 32'h0);
      p0 = rd;
      host_pins_inst.pulse(1'h0, 5);
      rchk(8'h0c, (p0 + 32'h5) & 32'h3ff);
      rchk(8'h08, 32'h8);
      chk(diag_out, 32'h0);
      warn <= 1'h1;
      shut <= 1'h1;
      repeat (8) @(posedge pclk);
      chk(bridge_enable, 32'h0);
      chk(diag_out, 32'h1);
      rchk(8'h10, 32'h3);
      shut <= 1'h0;
      repeat (8) @(posedge pclk);
      rchk(8'h10, 32'h3);
      chk(bridge_enable, 32'h0);
      warn <= 1'h0;
      repeat (8) @(posedge pclk);
      rchk(8'h10, 32'h0);
      apb(1'h1, 8'h00, 32'h4);
      repeat (2) @(posedge pclk);
      chk(bridge_enable, 32'h1);
      host_pins_inst.pulse(1'h1, 3);
      repeat (8) @(posedge pclk);
      chk(bridge_enable, 32'h1);
      host_pins_inst.pulse(1'h1, 1);
      repeat (8) @(posedge pclk);
      chk(bridge_enable, 32'h0);
      chk(diag_out, 32'h1);
      rchk(8'h10, 32'h24);
      chk(flags, 32'h24);
      apb(1'h1, 8'h00, 32'h4);
      repeat (2) @(posedge pclk);
      chk(bridge_enable, 32'h0);
      apb(1'h1, 8'h00, 32'h0);
      apb(1'h1, 8'h00, 32'h4);
      repeat (2) @(posedge pclk);
      chk(bridge_enable, 32'h1);
      shb <= 1'h1;
      host_pins_inst.pulse(1'h1, 4);
      repeat (8) @(posedge pclk);
      rchk(8'h10, 32'h18);
      chk(bridge_enable, 32'h0);
      apb(1'h1, 8'h00, 32'h0);
      apb(1'h1, 8'h00, 32'h4);
      repeat (2) @(posedge pclk);
      chk(bridge_enable, 32'h1);
      apb(1'h1, 8'h04, 32'h100000);
      ol <= 1'h1;
      repeat (8) @(posedge pclk);
      rchk(8'h10, 32'hc0);
      chk(bridge_enable, 32'h1);
      tally_and_finish();
   end
endmodule

// File: sim/stepgen_asserts.sv
// Purpose: Port assertions for the step generator and flags
// Assumes: Bound to step_generator_and_diag_flags
// Notes: Pins pass a two-flop synchroniser and a flag register
`timescale 1ns/10ps
module stepgen_asserts (
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Sensors and outputs
   input wire logic temp_warn_in,
   input wire logic temp_shut_in,
   input wire logic bridge_enable,
   input wire logic [9:0] microstep_position_count,
   input wire stepgen_diag_pkg::cond_flags_t driver_condition_flags
);
   import stepgen_diag_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic ot = driver_condition_flags.overtemp_shutdown_flag;
   wire logic shorts = |driver_condition_flags[5:2];
   wire logic wr_dis = psel && penable && pready && pwrite && paddr == 8'h00 && !pwdata[2];
   a_setup_gets_ready: assert property (psel && !penable |=> pready)
      else $error("No ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("Ready held too long");
   a_ot_bridge_off: assert property (ot |-> !bridge_enable)
      else $error("Bridge on during overtemp");
   a_short_bridge_off: assert property (shorts |-> !bridge_enable)
      else $error("Bridge on after short");
   a_off_no_motion: assert property (!bridge_enable [*2] |=> $stable(microstep_position_count))
      else $error("Position moved with bridges off");
   a_drop_has_cause: assert property ($fell(bridge_enable) |-> ot || shorts || $past(wr_dis) ||
      $past(wr_dis, 2))
      else $error("Bridge dropped without cause");
   a_ot_rise_cause: assert property ($rose(ot) |-> $past(temp_shut_in, 4))
      else $error("Overtemp set without sensor");
   a_ot_fall_cause: assert property ($fell(ot) |-> !$past(temp_warn_in, 4))
      else $error("Overtemp cleared above warning");
endmodule

bind step_generator_and_diag_flags stepgen_asserts stepgen_asserts_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .temp_warn_in, .temp_shut_in,
   .bridge_enable, .microstep_position_count, .driver_condition_flags);
